// [ssp_cfg.svh]
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Control byte field positions.
`define SSP_B_PINSEL     3
`define SSP_B_RDYEN      4
`define SSP_B_CLKINT     6
`define SSP_B_ODRAIN     7

// Control byte reset value: all pins plain ports.
`define SSP_CTRL_RST     8'h00

// Shift clock timing: oscillator 4 MHz divided by 32 gives 125 kHz.
`define SSP_OSC_HZ       4000000
`define SSP_OSC_DIV      32
`define SSP_SCLK_HZ      (`SSP_OSC_HZ / `SSP_OSC_DIV)
`define SSP_CORE_HZ      25000000
// Half period of the shift clock in core cycles, rounded down, at least one.
`define SSP_HALF_CYC     ((`SSP_CORE_HZ / (2 * `SSP_SCLK_HZ)) < 1 ? 1 : \
                          (`SSP_CORE_HZ / (2 * `SSP_SCLK_HZ)))

// Bits per transfer.
`define SSP_NBITS        8

`endif

// [ssp_peer.sv]
`timescale 1ns/1ps
// Selected peripheral: shifts a reply out LSB first, captures the incoming byte.
module ssp_peer (
    input  wire logic       i_clk_pin,
    input  wire logic       i_sel_b,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_reply,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh_r;
    logic [2:0] n_r;
    initial o_miso = 1'b0;
    // Frame start loads the reply; the line is inverted once released.
    always @(negedge i_sel_b) begin
        sh_r = i_reply;
        n_r = 3'h0;
    end
    always @(posedge i_sel_b) o_miso = ~o_miso;
    // Output changes on the falling clock, input is taken on the rising one.
    always @(negedge i_clk_pin) if (!i_sel_b) begin
        o_miso = sh_r[n_r];
        n_r = n_r + 3'h1;
    end
    always @(posedge i_clk_pin) if (!i_sel_b) o_rx = {i_mosi, o_rx[7:1]};
endmodule

// [ssp_pkg.sv]
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE  = 3'b001,
        SSP_LOW   = 3'b010,
        SSP_HIGH  = 3'b100
    } ssp_state_t;
endpackage

// [ssp_port.sv]
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module ssp_port #(
    parameter int HALF_CYC = `SSP_HALF_CYC,
    parameter int NBITS    = `SSP_NBITS
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_ctrl,
    input  wire logic [3:0]  i_port_dir,
    input  wire logic [3:0]  i_port_out,
    input  wire logic        i_data_wr,
    input  wire logic [7:0]  i_data_wdata,
    input  wire logic        i_rx_ready_req,
    input  wire logic        i_serial_in_pin,
    input  wire logic        i_shift_clock_pin,
    input  wire logic        i_serial_out_pin,
    input  wire logic        i_rx_ready_pin,
    output logic [7:0]  o_rx_data,
    output logic        o_busy,
    output logic        o_done,
    output logic [3:0]  o_port_in,
    output logic        o_serial_out_pin,
    output logic        o_serial_out_pin_oe_b,
    output logic        o_shift_clock_pin,
    output logic        o_shift_clock_pin_oe_b,
    output logic        o_rx_ready_pin,
    output logic        o_rx_ready_pin_oe_b,
    output logic        o_gpio_line_in_oe_b,
    output logic        o_gpio_line_in
);

    localparam int CW = $clog2(HALF_CYC + 1);

    // Control field decode.
    logic pinsel;
    logic clk_int;
    logic odrain;
    logic rdy_en;
    assign pinsel  = i_ctrl[`SSP_B_PINSEL];
    assign clk_int = i_ctrl[`SSP_B_CLKINT];
    assign odrain  = i_ctrl[`SSP_B_ODRAIN];
    assign rdy_en  = i_ctrl[`SSP_B_RDYEN];

    // Three-stage synchronisers for all four pins; stage one feeds stage two only.
    // A new level is taken once stages two and three agree, so a one-cycle glitch is dropped.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_q_r;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_s1_r <= 4'hf;
            pin_s2_r <= 4'hf;
            pin_s3_r <= 4'hf;
            pin_q_r  <= 4'hf;
        end else begin
            pin_s1_r <= {i_rx_ready_pin, i_shift_clock_pin, i_serial_out_pin, i_serial_in_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            for (int k = 0; k < 4; k++) begin
                if (pin_s2_r[k] == pin_s3_r[k]) begin
                    pin_q_r[k] <= pin_s3_r[k];
                end
            end
        end
    end

    // External clock edges are taken from the filtered level.
    // The delay register resets high like the pulled-up idle pin, so no false edge follows reset.
    logic ext_clk_d_r;
    logic ext_rise;
    logic ext_fall;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_clk_d_r <= 1'b1;
        end else begin
            ext_clk_d_r <= pin_q_r[2];
        end
    end
    assign ext_rise = pin_q_r[2] & ~ext_clk_d_r;
    assign ext_fall = ~pin_q_r[2] & ext_clk_d_r;

    // Divider: one-cycle enable every half shift clock period.
    // The count is held at zero while idle, so every transfer starts on a full half period.
    logic [CW-1:0] div_r;
    logic          half_tick;
    ssp_pkg::ssp_state_t state_r;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_r <= '0;
        end else if (state_r == ssp_pkg::SSP_IDLE || div_r == CW'(HALF_CYC - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + CW'(1);
        end
    end
    assign half_tick = (state_r != ssp_pkg::SSP_IDLE) && (div_r == CW'(HALF_CYC - 1));

    // Shift edges: falling edge shifts out, rising edge samples in.
    logic fall_ev;
    logic rise_ev;
    assign fall_ev = clk_int ? (half_tick && state_r == ssp_pkg::SSP_HIGH) : ext_fall;
    assign rise_ev = clk_int ? (half_tick && state_r == ssp_pkg::SSP_LOW) : ext_rise;

    // Transfer engine, LSB first.
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       sclk_r;
    logic       sout_r;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ssp_pkg::SSP_IDLE;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
            sclk_r  <= 1'b1;
            sout_r  <= 1'b1;
            o_done  <= 1'b0;
            o_rx_data <= 8'h00;
        end else begin
            o_done <= 1'b0;
            unique case (state_r)
                ssp_pkg::SSP_IDLE: begin
                    sclk_r <= 1'b1;
                    if (i_data_wr && pinsel) begin
                        sh_r    <= i_data_wdata;
                        sout_r  <= i_data_wdata[0];
                        cnt_r   <= 4'h0;
                        state_r <= ssp_pkg::SSP_HIGH;
                    end
                end
                ssp_pkg::SSP_HIGH: begin
                    if (fall_ev) begin
                        sclk_r  <= 1'b0;
                        sout_r  <= sh_r[0];
                        state_r <= ssp_pkg::SSP_LOW;
                    end
                end
                ssp_pkg::SSP_LOW: begin
                    if (rise_ev) begin
                        sclk_r <= 1'b1;
                        sh_r   <= {pin_q_r[0], sh_r[7:1]};
                        if (cnt_r == 4'(NBITS - 1)) begin
                            state_r   <= ssp_pkg::SSP_IDLE;
                            o_done    <= 1'b1;
                            o_rx_data <= {pin_q_r[0], sh_r[7:1]};
                        end else begin
                            cnt_r   <= cnt_r + 4'h1;
                            state_r <= ssp_pkg::SSP_HIGH;
                        end
                    end
                end
                default: begin
                    state_r <= ssp_pkg::SSP_IDLE;
                end
            endcase
            if (!pinsel) begin
                state_r <= ssp_pkg::SSP_IDLE;
            end
        end
    end

    // Pin drivers; output enables are active low.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_busy                 <= 1'b0;
            o_serial_out_pin       <= 1'b1;
            o_serial_out_pin_oe_b  <= 1'b1;
            o_shift_clock_pin      <= 1'b1;
            o_shift_clock_pin_oe_b <= 1'b1;
            o_rx_ready_pin         <= 1'b1;
            o_rx_ready_pin_oe_b    <= 1'b1;
            o_gpio_line_in         <= 1'b0;
            o_gpio_line_in_oe_b    <= 1'b1;
            o_port_in              <= 4'h0;
        end else begin
            o_busy    <= (state_r != ssp_pkg::SSP_IDLE);
            o_port_in <= pin_q_r;
            // Input pin: port output only when not serial and direction is out.
            o_gpio_line_in      <= i_port_out[0];
            o_gpio_line_in_oe_b <= pinsel | ~i_port_dir[0];
            // Output pin: open drain releases the line for a one.
            if (pinsel) begin
                o_serial_out_pin      <= sout_r;
                o_serial_out_pin_oe_b <= odrain & sout_r;
            end else begin
                o_serial_out_pin      <= i_port_out[1];
                o_serial_out_pin_oe_b <= ~i_port_dir[1] | (odrain & i_port_out[1]);
            end
            // Shift clock pin: in serial mode driven only as internal clock output.
            if (pinsel) begin
                o_shift_clock_pin      <= sclk_r;
                o_shift_clock_pin_oe_b <= ~clk_int;
            end else begin
                o_shift_clock_pin      <= i_port_out[2];
                o_shift_clock_pin_oe_b <= ~i_port_dir[2];
            end
            // Ready pin: low means this side can receive.
            // It is driven high while a transfer runs, so the partner never clocks a busy shifter.
            if (rdy_en) begin
                o_rx_ready_pin      <= ~(i_rx_ready_req && state_r == ssp_pkg::SSP_IDLE);
                o_rx_ready_pin_oe_b <= 1'b0;
            end else begin
                o_rx_ready_pin      <= i_port_out[3];
                o_rx_ready_pin_oe_b <= ~i_port_dir[3];
            end
        end
    end

endmodule

// [ssp_port_monitor.sv]
`timescale 1ns/1ps
// Checks pin selection and transfer handshakes at the port boundary.
module ssp_port_monitor (
    input wire logic       i_core_clk,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_ctrl,
    input wire logic [3:0] i_port_dir,
    input wire logic       i_data_wr,
    input wire logic       o_busy,
    input wire logic       o_done,
    input wire logic       o_serial_out_pin,
    input wire logic       o_serial_out_pin_oe_b,
    input wire logic       o_shift_clock_pin_oe_b,
    input wire logic       o_rx_ready_pin,
    input wire logic       o_rx_ready_pin_oe_b,
    input wire logic       o_gpio_line_in_oe_b
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Each pin output lags its control inputs by one clock.
    a_clk_int_out: assert property (i_ctrl[3] && i_ctrl[6] |=> !o_shift_clock_pin_oe_b)
        else $error("shift clock not driven");
    a_clk_ext_in: assert property (i_ctrl[3] && !i_ctrl[6] |=> o_shift_clock_pin_oe_b)
        else $error("shift clock driven in external mode");
    a_out_push_pull: assert property (i_ctrl[3] && !i_ctrl[7] |=> !o_serial_out_pin_oe_b)
        else $error("serial out not driven");
    a_out_open_drain: assert property (i_ctrl[3] && i_ctrl[7] |=> o_serial_out_pin_oe_b == o_serial_out_pin)
        else $error("open drain drives high");
    a_in_serial_sel: assert property (i_ctrl[3] |=> o_gpio_line_in_oe_b)
        else $error("serial in pin driven");
    a_rdy_as_port: assert property (!i_ctrl[4] && i_port_dir[3] |=> !o_rx_ready_pin_oe_b)
        else $error("ready port not driven");
    a_rdy_handshake: assert property (i_ctrl[4] |=> !o_rx_ready_pin_oe_b)
        else $error("ready pin not driven");
    a_rdy_busy_high: assert property ($past(i_ctrl[4]) && o_busy |-> o_rx_ready_pin)
        else $error("ready asserted while busy");
    a_wr_starts: assert property (i_data_wr && i_ctrl[3] && !o_busy ##1 i_ctrl[3] |=> o_busy)
        else $error("write did not start transfer");
    a_done_single: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
endmodule

bind ssp_port ssp_port_monitor ssp_port_monitor_inst (.*);

// [sync_serial_port_pin_select_test.sv]
`timescale 1ns/1ps
module sync_serial_port_pin_select_test;
    logic       clk = 0, rst_b = 0, wr = 0, req = 0, sel_b = 1, ext_ck = 1;
    logic [7:0] ctrl = 8'h00, wdata = 8'h00, reply = 8'h00, peer_rx, rx_data;
    logic [3:0] dir = 4'h0, pout = 4'h0, port_in;
    logic       busy, done, so, so_oe_b, ck, ck_oe_b, rdy, rdy_oe_b, gi, gi_oe_b, miso;
    int         n_errors = 0, n_checks = 0, seed = 32'h3adc703f;
    // The serial out and ready pins have pull-ups; the released clock pin follows a bench clock that idles high.
    wire so_w = so_oe_b ? 1'b1 : so;
    wire ck_w = ck_oe_b ? ext_ck : ck;
    wire rdy_w = rdy_oe_b ? 1'b1 : rdy;
    initial forever #20 clk = ~clk;
    ssp_port #(.HALF_CYC(8)) ssp_port_inst (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_ctrl(ctrl), .i_port_dir(dir), .i_port_out(pout), .i_data_wr(wr),
        .i_data_wdata(wdata), .i_rx_ready_req(req), .i_serial_in_pin(miso),
        .i_shift_clock_pin(ck_w), .i_serial_out_pin(so_w), .i_rx_ready_pin(rdy_w),
        .o_rx_data(rx_data), .o_busy(busy), .o_done(done), .o_port_in(port_in),
        .o_serial_out_pin(so), .o_serial_out_pin_oe_b(so_oe_b), .o_shift_clock_pin(ck),
        .o_shift_clock_pin_oe_b(ck_oe_b), .o_rx_ready_pin(rdy), .o_rx_ready_pin_oe_b(rdy_oe_b),
        .o_gpio_line_in_oe_b(gi_oe_b), .o_gpio_line_in(gi));
    ssp_peer ssp_peer_inst (.i_clk_pin(ck_w), .i_sel_b(sel_b), .i_mosi(so_w),
        .i_reply(reply), .o_miso(miso), .o_rx(peer_rx));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Writes one byte, clocks it from the bench in external mode, compares both directions.
    task automatic xfer(input logic [7:0] b, input bit ext);
        int i;
        wdata = b;
        wr = 1;
        @(negedge clk) wr = 0;
        if (ext) begin
            repeat (4) @(negedge clk);
            for (int j = 0; j < 8; j++) begin
                ext_ck = 0;
                repeat (10) @(negedge clk);
                ext_ck = 1;
                if (j < 7) repeat (10) @(negedge clk);
            end
        end
        for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
        if (done !== 1'b1) begin
            n_errors++;
            $display("BAD %0t no done pulse", $time);
            tally_and_finish;
        end else begin
            chk(rx_data, reply);
            // With the internal clock the peer takes the last bit a cycle after done, when the clock pin rises.
            repeat (2) @(negedge clk);
            chk(peer_rx, b);
        end
    endtask
    // Watchdog well beyond the expected run.
    initial begin
        #400000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1;
        // Port mode: writes are refused and pins follow the output bits.
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            pout = 4'($random(seed));
            dir = 4'hf;
            ctrl = k[0] ? 8'h80 : 8'h00;
            wr = 1;
            @(negedge clk) wr = 0;
            @(negedge clk);
            chk(busy, 1'b0);
            chk(gi, pout[0]);
            chk(so, pout[1]);
            chk(so_oe_b, k[0] & pout[1]);
            chk(rdy_oe_b, 1'b0);
            chk(rdy, pout[3]);
            chk(ck, pout[2]);
            chk(gi_oe_b, 1'b0);
            // Pin levels come back through the synchronisers a few cycles later.
            repeat (6) @(negedge clk);
            chk(port_in[3:1], pout[3:1]);
        end
        // Two-byte frames under select; odd frames take the shift clock from the bench.
        for (int k = 0; k < 12; k++) begin
            ctrl = (k[0] ? 8'h08 : 8'h48) | (8'h90 & 8'($random(seed)));
            req = 1'($random(seed));
            reply = 8'($random(seed));
            @(negedge clk) sel_b = 0;
            xfer(8'($random(seed)), k[0]);
            xfer(k < 2 ? 8'h00 : 8'hff, k[0]);
            sel_b = 1;
            @(negedge clk);
        end
        // Handshake pin low only when idle and receive wanted.
        ctrl = 8'h58;
        req = 1;
        repeat (3) @(negedge clk);
        chk(rdy, 0);
        req = 0;
        repeat (3) @(negedge clk);
        chk(rdy, 1);
        tally_and_finish;
    end
endmodule
